// *** design/sfd_pkg.sv ***
// shared constants, types and opcode table for the flash command decoder
package sfd_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int MCLK_MHZ = 100;
	localparam int CS_HIGH_NS = 50;
	localparam int CS_SETTLE_CYC = (CS_HIGH_NS * MCLK_MHZ + 999) / 1000;
	localparam logic [3:0] SETTLE_LOAD = 4'(CS_SETTLE_CYC);

	// ****************************************************************
	// link and field sizes
	// ****************************************************************
	localparam logic [2:0] STEP_SINGLE = 3'h1;
	localparam logic [2:0] STEP_FOUR = 3'h4;
	localparam logic [1:0] ADDR_BYTES = 2'h3;
	localparam logic [2:0] DUMMY_ONE = 3'h1;
	localparam logic [2:0] DUMMY_THREE = 3'h3;
	localparam logic [2:0] DUMMY_FOUR = 3'h4;

	// ****************************************************************
	// opcodes
	// ****************************************************************
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_VOL_WEN = 8'h50;
	localparam logic [7:0] OP_WRDIS = 8'h04;
	localparam logic [7:0] OP_ID_PD = 8'hab;
	localparam logic [7:0] OP_MFID = 8'h90;
	localparam logic [7:0] OP_MFID2 = 8'h92;
	localparam logic [7:0] OP_MFID4 = 8'h94;
	localparam logic [7:0] OP_JEDEC = 8'h9f;
	localparam logic [7:0] OP_UID = 8'h4b;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FREAD = 8'h0b;
	localparam logic [7:0] OP_WRAP_RD = 8'h0c;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
	localparam logic [7:0] OP_DUAL_IO = 8'hbb;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
	localparam logic [7:0] OP_QUAD_IO = 8'heb;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_QPROG = 8'h32;
	localparam logic [7:0] OP_ERASE4K = 8'h20;
	localparam logic [7:0] OP_ERASE32K = 8'h52;
	localparam logic [7:0] OP_ERASE64K = 8'hd8;
	localparam logic [7:0] OP_CHIP_ER = 8'hc7;
	localparam logic [7:0] OP_CHIP_ER2 = 8'h60;
	localparam logic [7:0] OP_STAT_RD1 = 8'h05;
	localparam logic [7:0] OP_STAT_RD2 = 8'h35;
	localparam logic [7:0] OP_STAT_RD3 = 8'h15;
	localparam logic [7:0] OP_STAT_WR1 = 8'h01;
	localparam logic [7:0] OP_STAT_WR2 = 8'h31;
	localparam logic [7:0] OP_STAT_WR3 = 8'h11;
	localparam logic [7:0] OP_PARAM_RD = 8'h5a;
	localparam logic [7:0] OP_SEC_ER = 8'h44;
	localparam logic [7:0] OP_SEC_PROG = 8'h42;
	localparam logic [7:0] OP_SEC_RD = 8'h48;
	localparam logic [7:0] OP_GLOCK = 8'h7e;
	localparam logic [7:0] OP_GUNLOCK = 8'h98;
	localparam logic [7:0] OP_LOCK_RD = 8'h3d;
	localparam logic [7:0] OP_LOCK = 8'h36;
	localparam logic [7:0] OP_UNLOCK = 8'h39;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_PDOWN = 8'hb9;
	localparam logic [7:0] OP_FOUR_ON = 8'h38;
	localparam logic [7:0] OP_FOUR_OFF = 8'hff;
	localparam logic [7:0] OP_WRAP_SET = 8'h77;
	localparam logic [7:0] OP_RD_PARAM = 8'hc0;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST_DO = 8'h99;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		CLS_CTRL = 2'h0,
		CLS_READ = 2'h1,
		CLS_WRITE = 2'h2,
		CLS_PROG = 2'h3
	} sfd_cls_e;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_DATA = 6'h04,
		ST_HOLD = 6'h08,
		ST_READ = 6'h10,
		ST_DROP = 6'h20
	} sfd_state_e;

	typedef struct packed {
		logic legal;
		logic [1:0] addr_n;
		logic [2:0] dummy_n;
		logic has_data;
		sfd_cls_e cls;
	} sfd_opinfo_s;

	typedef struct packed {
		logic first;
		logic [7:0] data;
	} sfd_link_byte_s;

	typedef struct packed {
		logic [7:0] opcode;
		logic [23:0] addr;
		sfd_cls_e cls;
		logic [2:0] dummy_n;
	} sfd_cmd_s;

endpackage

// *** design/sfd_async_fifo.sv ***
// gray-pointer fifo carrying link bytes into the system clock domain
`timescale 1ns/1ns
module sfd_async_fifo #(
	parameter int W = 9,
	parameter int AW = 3
) (
	// write side, link clock
	input wire logic wclk,
	input wire logic wrst_n,
	input wire logic w_valid,
	output logic w_ready,
	input wire logic [W-1:0] w_data,
	// read side, system clock
	input wire logic rclk,
	input wire logic rrst_n,
	output logic r_valid,
	input wire logic r_ready,
	output logic [W-1:0] r_data
);
	logic [W-1:0] mem [2**AW];
	logic [AW:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
	logic [AW:0] rg_w1_reg, rg_w2_reg, wg_r1_reg, wg_r2_reg;
	logic [AW:0] wbin_next, rbin_next;

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	// full when write gray is read gray with top two bits flipped
	assign w_ready = wgray_reg != {~rg_w2_reg[AW:AW-1], rg_w2_reg[AW-2:0]};
	assign r_valid = rgray_reg != wg_r2_reg;
	assign r_data = mem[rbin_reg[AW-1:0]];
	assign wbin_next = wbin_reg + {{AW{1'b0}}, 1'b1};
	assign rbin_next = rbin_reg + {{AW{1'b0}}, 1'b1};

	// storage
	always_ff @(posedge wclk) begin
		if (w_valid && w_ready) begin
			mem[wbin_reg[AW-1:0]] <= w_data;
		end
	end

	// write pointer and read pointer sync
	always_ff @(posedge wclk or negedge wrst_n) begin
		if (!wrst_n) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
			rg_w1_reg <= '0;
			rg_w2_reg <= '0;
		end else begin
			rg_w1_reg <= rgray_reg;
			rg_w2_reg <= rg_w1_reg;
			if (w_valid && w_ready) begin
				wbin_reg <= wbin_next;
				wgray_reg <= to_gray(wbin_next);
			end
		end
	end

	// read pointer and write pointer sync
	always_ff @(posedge rclk or negedge rrst_n) begin
		if (!rrst_n) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
			wg_r1_reg <= '0;
			wg_r2_reg <= '0;
		end else begin
			wg_r1_reg <= wgray_reg;
			wg_r2_reg <= wg_r1_reg;
			if (r_valid && r_ready) begin
				rbin_reg <= rbin_next;
				rgray_reg <= to_gray(rbin_next);
			end
		end
	end
endmodule

// *** design/sfd_skid2.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module sfd_skid2 #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] d0_reg, d1_reg;
	logic v0_reg, v1_reg;
	logic push, pop;

	assign in_ready = ~v1_reg;
	assign out_valid = v0_reg;
	assign out_data = d0_reg;
	assign push = in_valid & ~v1_reg;
	assign pop = v0_reg & out_ready;

	// entry 0 is the head, entry 1 the spill slot
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			d0_reg <= '0;
			d1_reg <= '0;
			v0_reg <= 1'b0;
			v1_reg <= 1'b0;
		end else if (pop) begin
			d0_reg <= v1_reg ? d1_reg : in_data;
			v0_reg <= v1_reg | push;
			if (v1_reg && push) begin
				d1_reg <= in_data;
			end
			v1_reg <= v1_reg & push;
		end else if (push) begin
			if (!v0_reg) begin
				d0_reg <= in_data;
				v0_reg <= 1'b1;
			end else begin
				d1_reg <= in_data;
				v1_reg <= 1'b1;
			end
		end
	end
endmodule

// *** design/sfd_decoder.sv ***
// serial flash command decoder: link capture, crossing and decode
`timescale 1ns/1ns
// ****************************************************************
// Summary of operation
// [R01] select falling edge starts a new instruction
// [R02] single-wire: first byte is the opcode
// [R03] rising clock samples input, msb first
// [R04] four-wire: first nibble pair is the opcode
// [R05] four-wire: four lines sampled together, msb first
// [R06] four-wire: every byte takes two clocks
// [R07] full single and four-wire opcode repertoire decoded
// [R08] opcode sets address, dummy and data phases
// [R09] select rising edge completes and executes instruction
// [R10] reads may stop after any bit
// [R11] writes ignored unless whole bytes were sent
// [R12] while busy only read status accepted
// [R13] 06h, 50h, 04h drive the write enables
// [R14] 75h suspends, 7Ah resumes
// [R15] program or erase of locked region ignored
// [R16] 03h read, 0Bh fast read with dummy
// [R17] program, block erases and chip erase decoded
// [R18] 66h then 99h gives a software reset
// ****************************************************************
module sfd_decoder #(
	parameter int FIFO_AW = 3
) (
	// clocks and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic sclk,
	// link pins
	input wire logic cs_n,
	input wire logic [3:0] io_in,
	// array and lock logic status
	input wire logic busy,
	input wire logic region_locked,
	// decoded command
	output sfd_pkg::sfd_cmd_s cmd,
	output logic cmd_valid,
	output logic discard,
	output logic read_stop,
	output logic soft_rst,
	// device mode and enables
	output logic wel,
	output logic vol_wen,
	output logic four_mode,
	// write data stream
	output logic [7:0] wr_data,
	output logic wr_valid,
	input wire logic wr_ready
);

	// ****************************************************************
	// opcode table
	// ****************************************************************
	function automatic sfd_pkg::sfd_opinfo_s op_info(
		input logic [7:0] op, input logic four);
		sfd_pkg::sfd_opinfo_s i;
		logic single_only;
		logic four_only;
		i = '{1'b1, 2'h0, 3'h0, 1'b0, sfd_pkg::CLS_CTRL};
		single_only = 1'b0;
		four_only = 1'b0;
		case (op)
		sfd_pkg::OP_WREN, sfd_pkg::OP_VOL_WEN, sfd_pkg::OP_WRDIS,
		sfd_pkg::OP_GLOCK, sfd_pkg::OP_GUNLOCK, sfd_pkg::OP_PDOWN,
		sfd_pkg::OP_RST_EN, sfd_pkg::OP_RST_DO: ;  // [R13]
		sfd_pkg::OP_SUSPEND, sfd_pkg::OP_RESUME: ;  // [R14]
		sfd_pkg::OP_FOUR_ON: single_only = 1'b1;
		sfd_pkg::OP_FOUR_OFF: four_only = 1'b1;
		sfd_pkg::OP_STAT_RD1, sfd_pkg::OP_STAT_RD2, sfd_pkg::OP_STAT_RD3,
		sfd_pkg::OP_JEDEC: i.cls = sfd_pkg::CLS_READ;
		sfd_pkg::OP_ID_PD: begin
			i.cls = sfd_pkg::CLS_READ;
			i.dummy_n = sfd_pkg::DUMMY_THREE;
		end
		sfd_pkg::OP_UID: begin
			i.cls = sfd_pkg::CLS_READ;
			i.dummy_n = sfd_pkg::DUMMY_FOUR;
			single_only = 1'b1;
		end
		sfd_pkg::OP_STAT_WR1, sfd_pkg::OP_STAT_WR2, sfd_pkg::OP_STAT_WR3,
		sfd_pkg::OP_RD_PARAM: begin
			i.cls = sfd_pkg::CLS_WRITE;
			i.has_data = 1'b1;
			four_only = op == sfd_pkg::OP_RD_PARAM;
		end
		sfd_pkg::OP_WRAP_SET: begin
			i.cls = sfd_pkg::CLS_WRITE;
			i.has_data = 1'b1;
			i.dummy_n = sfd_pkg::DUMMY_THREE;
			single_only = 1'b1;
		end
		sfd_pkg::OP_READ, sfd_pkg::OP_MFID, sfd_pkg::OP_MFID2,
		sfd_pkg::OP_MFID4, sfd_pkg::OP_LOCK_RD: begin
			i.cls = sfd_pkg::CLS_READ;  // [R16]
			i.addr_n = sfd_pkg::ADDR_BYTES;
			single_only = op != sfd_pkg::OP_MFID && op != sfd_pkg::OP_LOCK_RD;
		end
		sfd_pkg::OP_FREAD, sfd_pkg::OP_WRAP_RD, sfd_pkg::OP_DUAL_OUT,
		sfd_pkg::OP_DUAL_IO, sfd_pkg::OP_QUAD_OUT, sfd_pkg::OP_QUAD_IO,
		sfd_pkg::OP_PARAM_RD, sfd_pkg::OP_SEC_RD: begin
			i.cls = sfd_pkg::CLS_READ;  // [R16]
			i.addr_n = sfd_pkg::ADDR_BYTES;
			i.dummy_n = sfd_pkg::DUMMY_ONE;
			four_only = op == sfd_pkg::OP_WRAP_RD;
			single_only = op != sfd_pkg::OP_FREAD && op != sfd_pkg::OP_QUAD_IO
				&& op != sfd_pkg::OP_WRAP_RD;
		end
		sfd_pkg::OP_PROG, sfd_pkg::OP_QPROG: begin
			i.cls = sfd_pkg::CLS_PROG;  // [R17]
			i.addr_n = sfd_pkg::ADDR_BYTES;
			i.has_data = 1'b1;
			single_only = op == sfd_pkg::OP_QPROG;
		end
		sfd_pkg::OP_ERASE4K, sfd_pkg::OP_ERASE32K,
		sfd_pkg::OP_ERASE64K: begin
			i.cls = sfd_pkg::CLS_PROG;  // [R17]
			i.addr_n = sfd_pkg::ADDR_BYTES;
		end
		sfd_pkg::OP_CHIP_ER, sfd_pkg::OP_CHIP_ER2:
			i.cls = sfd_pkg::CLS_PROG;  // [R17]
		sfd_pkg::OP_SEC_ER, sfd_pkg::OP_LOCK, sfd_pkg::OP_UNLOCK: begin
			i.cls = sfd_pkg::CLS_WRITE;
			i.addr_n = sfd_pkg::ADDR_BYTES;
			single_only = op == sfd_pkg::OP_SEC_ER;
		end
		sfd_pkg::OP_SEC_PROG: begin
			i.cls = sfd_pkg::CLS_WRITE;
			i.addr_n = sfd_pkg::ADDR_BYTES;
			i.has_data = 1'b1;
			single_only = 1'b1;
		end
		default: i.legal = 1'b0;
		endcase
		if ((four && single_only) || (!four && four_only)) begin
			i.legal = 1'b0;  // [R07]
		end
		return i;
	endfunction

	// state reached once address bytes, and dummy bytes of data commands, are in
	function automatic sfd_pkg::sfd_state_e after_addr(
		input sfd_pkg::sfd_cls_e cls, input logic has_data);
		if (cls == sfd_pkg::CLS_READ) begin
			return sfd_pkg::ST_READ;
		end
		return has_data ? sfd_pkg::ST_DATA : sfd_pkg::ST_HOLD;
	endfunction

	// ****************************************************************
	// link domain
	// ****************************************************************
	logic frame_rst_n;
	logic four_s1_reg, four_s2_reg;
	logic in_frame_reg, byte_seen_reg;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic part_reg;
	logic four_mode_reg;
	logic lk_push;
	sfd_pkg::sfd_link_byte_s lk_byte;

	// select high clears the frame flags without a clock
	assign frame_rst_n = rstn & ~cs_n;  // [R01]
	assign lk_push = bit_cnt_next == 3'h0;
	assign lk_byte = '{~byte_seen_reg, shift_next};  // [R02] [R04]

	// mode level into the link clock
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			four_s1_reg <= 1'b0;
			four_s2_reg <= 1'b0;
		end else begin
			four_s1_reg <= four_mode_reg;
			four_s2_reg <= four_s1_reg;
		end
	end

	// frame flags
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			in_frame_reg <= 1'b0;
			byte_seen_reg <= 1'b0;
		end else begin
			in_frame_reg <= 1'b1;
			if (lk_push) begin
				byte_seen_reg <= 1'b1;
			end
		end
	end

	// next shift value and bit count
	always_comb begin
		bit_cnt_next = in_frame_reg ? bit_cnt_reg : 3'h0;  // [R01]
		if (four_s2_reg) begin
			shift_next = {shift_reg[3:0], io_in};  // [R05]
			bit_cnt_next = bit_cnt_next + sfd_pkg::STEP_FOUR;  // [R06]
		end else begin
			shift_next = {shift_reg[6:0], io_in[0]};  // [R03]
			bit_cnt_next = bit_cnt_next + sfd_pkg::STEP_SINGLE;
		end
	end

	// shifter; count and partial flag hold after select rises
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			part_reg <= 1'b0;
		end else begin
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			part_reg <= bit_cnt_next != 3'h0;  // [R11]
		end
	end

	// ****************************************************************
	// crossing into the system clock
	// ****************************************************************
	logic f_valid, pop;
	sfd_pkg::sfd_link_byte_s f_byte;
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg, part_s1_reg, part_s2_reg;

	sfd_async_fifo #(.W(9), .AW(FIFO_AW)) u_fifo (
		.wclk(sclk),
		.wrst_n(rstn),
		.w_valid(lk_push),
		.w_ready(),
		.w_data(lk_byte),
		.rclk(mclk),
		.rrst_n(rstn),
		.r_valid(f_valid),
		.r_ready(pop),
		.r_data(f_byte)
	);

	// select and partial flag synchronisers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			part_s1_reg <= 1'b0;
			part_s2_reg <= 1'b0;
		end else begin
			cs_s1_reg <= cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			part_s1_reg <= part_reg;
			part_s2_reg <= part_s1_reg;
		end
	end

	// ****************************************************************
	// decode
	// ****************************************************************
	sfd_pkg::sfd_state_e state_reg, state_next;
	sfd_pkg::sfd_opinfo_s info;
	sfd_pkg::sfd_cmd_s cmd_reg;
	logic [2:0] left_reg, left_next;
	logic [3:0] settle_reg;
	logic end_pend_reg, hd_reg, data_seen_reg;
	logic finish, sk_push, sk_ready, read_go, accept;
	logic cmd_valid_reg, discard_reg, read_stop_reg, soft_rst_reg;
	logic wel_reg, vol_wen_reg, arm_reg;

	assign info = op_info(f_byte.data, four_mode_reg);
	assign finish = end_pend_reg && settle_reg == 4'h0 &&
		(!f_valid || f_byte.first);  // [R09]
	assign pop = f_valid && !(f_byte.first && end_pend_reg) &&
		(f_byte.first || state_reg != sfd_pkg::ST_DATA || sk_ready);
	assign sk_push = pop && !f_byte.first && state_reg == sfd_pkg::ST_DATA;
	assign read_go = state_next == sfd_pkg::ST_READ &&
		state_reg != sfd_pkg::ST_READ;

	// acceptance at the end of the frame
	always_comb begin
		accept = finish && (state_reg == sfd_pkg::ST_HOLD ||
			(state_reg == sfd_pkg::ST_DATA && data_seen_reg));
		if (cmd_reg.cls == sfd_pkg::CLS_WRITE ||
			cmd_reg.cls == sfd_pkg::CLS_PROG) begin
			accept = accept && !part_s2_reg;  // [R11]
		end
		if (cmd_reg.cls == sfd_pkg::CLS_PROG && region_locked) begin
			accept = 1'b0;  // [R15]
		end
	end

	// frame end: wait for the last bytes to cross
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			end_pend_reg <= 1'b0;
			settle_reg <= 4'h0;
		end else if (cs_s2_reg && !cs_s3_reg) begin
			end_pend_reg <= 1'b1;  // [R09]
			settle_reg <= sfd_pkg::SETTLE_LOAD;
		end else if (finish) begin
			end_pend_reg <= 1'b0;
		end else if (settle_reg != 4'h0) begin
			settle_reg <= settle_reg - 4'h1;
		end
	end

	// phase sequencing
	always_comb begin
		state_next = state_reg;
		left_next = left_reg;
		if (finish) begin
			state_next = sfd_pkg::ST_IDLE;
		end else if (pop && f_byte.first) begin
			left_next = {1'b0, info.addr_n} +
				(info.has_data ? info.dummy_n : 3'h0);  // [R08]
			if (!info.legal ||
				(busy && f_byte.data != sfd_pkg::OP_STAT_RD1)) begin
				state_next = sfd_pkg::ST_DROP;  // [R12]
			end else if (left_next != 3'h0) begin
				state_next = sfd_pkg::ST_ADDR;
			end else begin
				state_next = after_addr(info.cls, info.has_data);
			end
		end else if (pop && state_reg == sfd_pkg::ST_ADDR) begin
			left_next = left_reg - 3'h1;
			if (left_next == 3'h0) begin
				state_next = after_addr(cmd_reg.cls, hd_reg);  // [R08]
			end
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= sfd_pkg::ST_IDLE;
			left_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			left_reg <= left_next;
		end
	end

	// opcode and address capture
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cmd_reg <= '0;
			hd_reg <= 1'b0;
			data_seen_reg <= 1'b0;
		end else if (pop && f_byte.first) begin
			cmd_reg <= '{f_byte.data, 24'h000000, info.cls, info.dummy_n};
			hd_reg <= info.has_data;
			data_seen_reg <= 1'b0;
		end else if (pop && state_reg == sfd_pkg::ST_ADDR) begin
			cmd_reg.addr <= {cmd_reg.addr[15:0], f_byte.data};  // [R16]
		end else if (sk_push) begin
			data_seen_reg <= 1'b1;
		end
	end

	// command pulses
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cmd_valid_reg <= 1'b0;
			discard_reg <= 1'b0;
			read_stop_reg <= 1'b0;
		end else begin
			cmd_valid_reg <= accept || read_go;
			discard_reg <= finish && !accept &&
				state_reg == sfd_pkg::ST_DATA;
			read_stop_reg <= finish && state_reg == sfd_pkg::ST_READ;  // [R10]
		end
	end

	// write enables, mode and reset arming
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wel_reg <= 1'b0;
			vol_wen_reg <= 1'b0;
			four_mode_reg <= 1'b0;
			arm_reg <= 1'b0;
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= accept && arm_reg &&
				cmd_reg.opcode == sfd_pkg::OP_RST_DO;  // [R18]
			if (finish) begin
				arm_reg <= accept && cmd_reg.opcode == sfd_pkg::OP_RST_EN;
			end
			if (soft_rst_reg) begin
				wel_reg <= 1'b0;
				vol_wen_reg <= 1'b0;
				four_mode_reg <= 1'b0;
			end else if (accept) begin
				unique case (cmd_reg.opcode)
				sfd_pkg::OP_WREN: wel_reg <= 1'b1;  // [R13]
				sfd_pkg::OP_WRDIS: begin
					wel_reg <= 1'b0;  // [R13]
					vol_wen_reg <= 1'b0;
				end
				sfd_pkg::OP_VOL_WEN: vol_wen_reg <= 1'b1;  // [R13]
				sfd_pkg::OP_FOUR_ON: four_mode_reg <= 1'b1;
				sfd_pkg::OP_FOUR_OFF: four_mode_reg <= 1'b0;
				default: ;
				endcase
			end
		end
	end

	// ****************************************************************
	// write data buffer and outputs
	// ****************************************************************
	sfd_skid2 #(.W(8)) u_buf (
		.clk(mclk),
		.rstn(rstn),
		.in_valid(sk_push),
		.in_ready(sk_ready),
		.in_data(f_byte.data),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(wr_data)
	);

	assign cmd = cmd_reg;
	assign cmd_valid = cmd_valid_reg;
	assign discard = discard_reg;
	assign read_stop = read_stop_reg;
	assign soft_rst = soft_rst_reg;
	assign wel = wel_reg;
	assign vol_wen = vol_wen_reg;
	assign four_mode = four_mode_reg;
endmodule

// *** sim/sfd_props.sv ***
// port assertions for the flash command decoder
`timescale 1ns/1ns
module sfd_props (
	// clocks, link and status inputs
	input logic mclk, rstn, sclk, cs_n, busy, region_locked,
	input logic [3:0] io_in,
	// decoded results and write stream
	input sfd_pkg::sfd_cmd_s cmd,
	input logic cmd_valid, discard, read_stop, soft_rst, wel,
	input logic vol_wen, four_mode, wr_valid, wr_ready,
	input logic [7:0] wr_data
);
	// ********
	// checks
	// ********
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_one_pulse: assert property (cmd_valid |=> !cmd_valid)
		else $error("cmd_valid too long");
	a_after_cs: assert property (cmd_valid &&
		cmd.cls != sfd_pkg::CLS_READ |-> $past(cs_n, 6))
		else $error("accepted inside frame");
	a_wel_set: assert property ($rose(wel) |->
		cmd_valid && cmd.opcode == sfd_pkg::OP_WREN)
		else $error("wel set without 06h");
	a_wel_clr: assert property ($fell(wel) |-> soft_rst ||
		$past(soft_rst) || cmd_valid && cmd.opcode == sfd_pkg::OP_WRDIS)
		else $error("wel cleared without 04h");
	a_busy_gate: assert property (cmd_valid && busy &&
		$past(busy, 8) |-> cmd.opcode == sfd_pkg::OP_STAT_RD1)
		else $error("accepted while busy");
	a_lock_gate: assert property (cmd_valid &&
		cmd.cls == sfd_pkg::CLS_PROG |-> !$past(region_locked))
		else $error("locked region changed");
	a_stop_read: assert property (read_stop |->
		cmd.cls == sfd_pkg::CLS_READ)
		else $error("read_stop on non-read");
	a_rst_pair: assert property (soft_rst |->
		cmd.opcode == sfd_pkg::OP_RST_DO)
		else $error("soft_rst without 99h");
	a_wr_hold: assert property (wr_valid && !wr_ready |->
		##1 wr_valid && $stable(wr_data))
		else $error("write byte lost");
	cover property (cmd_valid && cmd.cls == sfd_pkg::CLS_PROG);
	cover property (soft_rst);
	cover property (discard);
endmodule
bind sfd_decoder sfd_props u_sfd_props (.mclk, .rstn, .sclk, .cs_n,
	.busy, .region_locked, .io_in, .cmd, .cmd_valid, .discard,
	.read_stop, .soft_rst, .wel, .vol_wen, .four_mode, .wr_valid,
	.wr_ready, .wr_data);

// *** sim/sfd_host_model.sv ***
// host model driving select, serial clock and data lines
`timescale 1ns/1ns
module sfd_host_model (
	// link pins
	output logic cs_n,
	output logic sclk,
	output logic [3:0] io_in
);
	// ********
	// frames
	// ********
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io_in = 4'h0;
	end
	// one rising edge; clock stands still otherwise
	task automatic tick();
		#3 sclk = 1'b1;
		#3 sclk = 1'b0;
	endtask
	// two rises with select high after a mode change
	task automatic idle();
		repeat (2) tick();
	endtask
	// bytes msb first, then tail bits of a cut frame
	task automatic frame(input logic [7:0] q[$], input int tail,
		input bit four);
		logic [7:0] b;
		cs_n = 1'b0;
		foreach (q[i]) begin
			b = q[i];
			repeat (four ? 2 : 8) begin
				io_in = four ? b[7:4] : {~{3{b[7]}}, b[7]};
				b = four ? b << 4 : b << 1;
				tick();
			end
		end
		repeat (tail) begin
			io_in = ~io_in;
			tick();
		end
		#3 cs_n = 1'b1;
		io_in = ~io_in;
	endtask
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the flash command decoder
`timescale 1ns/1ns
module tb_top;
	// ********
	// bench state and design
	// ********
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic busy = 1'b0;
	logic region_locked = 1'b0;
	logic wr_ready = 1'b1;
	logic cs_n, sclk, cmd_valid, discard, read_stop, soft_rst;
	logic wel, vol_wen, four_mode, wr_valid;
	logic [3:0] io_in;
	logic [7:0] wr_data;
	sfd_pkg::sfd_cmd_s cmd, last;
	logic [7:0] wq[$];
	int mismatches = 0;
	int cmp_count = 0;
	int n_acc, n_disc, n_stop, n_rst;
	always #5 mclk = ~mclk;
	sfd_decoder u_sfd_decoder (.mclk, .rstn, .sclk, .cs_n, .io_in, .busy,
		.region_locked, .cmd, .cmd_valid, .discard, .read_stop,
		.soft_rst, .wel, .vol_wen, .four_mode, .wr_data, .wr_valid,
		.wr_ready);
	sfd_host_model u_sfd_host_model (.cs_n, .sclk, .io_in);
	// tally pulses and taken write bytes
	always @(posedge mclk) begin
		if (cmd_valid === 1'b1) begin
			n_acc++;
			last = cmd;
		end
		if (discard === 1'b1) n_disc++;
		if (read_stop === 1'b1) n_stop++;
		if (soft_rst === 1'b1) n_rst++;
		if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back(wr_data);
	end
	// ********
	// helpers
	// ********
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_n(string nm, int e, int g);
		chk(nm, 32'(e), 32'(g));
	endtask
	// one frame, then settle well past the acceptance point
	task automatic go(input logic [7:0] q[$], input int tail = 0,
		input bit four = 1'b0);
		{n_acc, n_disc, n_stop, n_rst} = '0;
		wq.delete();
		u_sfd_host_model.frame(q, tail, four);
		repeat (30) @(posedge mclk);
		#1;
	endtask
	task automatic tally_and_finish();
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_enables();
		go('{8'h06});
		chk("wel", 1, wel);
		chk("opcode", sfd_pkg::OP_WREN, last.opcode);
		go('{8'h50});
		chk("vol_wen", 1, vol_wen);
		go('{8'h04});
		chk("enables", 0, {wel, vol_wen});
	endtask
	task automatic t_read();
		go('{8'h03, 8'h12, 8'h34, 8'h56}, 3);
		chk_n("accepted", 1, n_acc);
		chk("addr", 32'h123456, last.addr);
		chk("cls", sfd_pkg::CLS_READ, last.cls);
		chk_n("stops", 1, n_stop);
		go('{8'h0b, 8'hab, 8'hcd, 8'hef, 8'h00}, 5);
		chk("dummy", sfd_pkg::DUMMY_ONE, last.dummy_n);
	endtask
	task automatic t_prog();
		wr_ready = 1'b0;
		fork
			go('{8'h02, 8'h00, 8'h01, 8'h00, 8'ha5, 8'h5a});
			begin
				repeat (34) @(posedge mclk);
				#1 wr_ready = 1'b1;
			end
		join
		chk_n("bytes", 2, wq.size());
		chk("byte0", 8'ha5, wq[0]);
		chk("byte1", 8'h5a, wq[1]);
		chk("cls", sfd_pkg::CLS_PROG, last.cls);
	endtask
	task automatic t_partial();
		go('{8'h20, 8'h00, 8'h10, 8'h00}, 3);
		chk_n("accepted", 0, n_acc);
		go('{8'h02, 8'h00, 8'h00, 8'h00, 8'h11}, 4);
		chk_n("discards", 1, n_disc);
		chk_n("accepted", 0, n_acc);
	endtask
	task automatic t_erase();
		logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
		foreach (ops[i]) begin
			if (i < 3)
				go('{ops[i], 8'h1f, 8'hf0, 8'h00});
			else
				go('{ops[i]});
			chk("erase op", ops[i], last.opcode);
			chk("cls", sfd_pkg::CLS_PROG, last.cls);
		end
		region_locked = 1'b1;
		go('{8'h20, 8'h00, 8'h00, 8'h00});
		chk_n("accepted", 0, n_acc);
		region_locked = 1'b0;
	endtask
	task automatic t_busy();
		busy = 1'b1;
		go('{8'h06});
		chk_n("accepted", 0, n_acc);
		go('{8'h05, 8'h00});
		chk_n("accepted", 1, n_acc);
		busy = 1'b0;
	endtask
	task automatic t_suspend();
		go('{8'h75});
		chk("opcode", sfd_pkg::OP_SUSPEND, last.opcode);
		go('{8'h7a});
		chk("opcode", sfd_pkg::OP_RESUME, last.opcode);
	endtask
	task automatic t_four();
		go('{8'h38});
		chk("four_mode", 1, four_mode);
		u_sfd_host_model.idle();
		go('{8'h06}, 0, 1);
		chk("wel", 1, wel);
		go('{8'h0b, 8'h01, 8'h02, 8'h03}, 0, 1);
		chk("addr", 32'h010203, last.addr);
		go('{8'h38}, 0, 1);
		chk_n("accepted", 0, n_acc);
		go('{8'hff}, 0, 1);
		chk("four_mode", 0, four_mode);
		u_sfd_host_model.idle();
	endtask
	task automatic t_soft();
		go('{8'h66});
		go('{8'h99});
		chk_n("resets", 1, n_rst);
		go('{8'h66});
		go('{8'h04});
		go('{8'h99});
		chk_n("resets", 0, n_rst);
	endtask
	// reset, then scenarios in order
	initial begin
		repeat (10) @(posedge mclk);
		#1 rstn = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		t_enables();
		t_read();
		t_prog();
		t_partial();
		t_erase();
		t_busy();
		t_suspend();
		t_four();
		t_soft();
		tally_and_finish();
	end
	// watchdog against a hang
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
endmodule
